// ===== hw/monitor_mode_alarm_control.sv
/*
 monitor_mode_alarm_control: mode decode, latching alarm and alert, failure latch,
 threshold adjust pop-up with save timeout, purge countdown, relay test at power-up,
 and an AXI4-Lite register slave.
 assumes switch and button inputs already debounced and synchronous to ref_clk_i;
 the button press is a one-cycle pulse, the knob step is a one-cycle pulse with a direction.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module monitor_mode_alarm_control #(
    parameter int unsigned POPUP_CYC = monitor_pkg::POPUP_CYCLES,
    parameter int unsigned RELAY_CYC = monitor_pkg::RELAY_CYCLES,
    parameter int unsigned SEC_CYC = monitor_pkg::SEC_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] selector_i,
    input wire logic ack_press_i,
    input wire logic knob_step_i,
    input wire logic knob_up_i,
    input wire logic mains_i,
    input wire logic [7:0] diag_ok_i,
    input wire logic airflow_low_i,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output monitor_pkg::actuator_type act_o,
    output monitor_pkg::display_type disp_o,
    output monitor_pkg::sounder_type sound_o
);

    // selector one-hot decode, illegal or no position reads as off
    function automatic monitor_pkg::mode_type decode_mode(input logic [4:0] sel);
        monitor_pkg::mode_type m;
        m = monitor_pkg::MODE_OFF;
        unique case (sel)
            5'h02: m = monitor_pkg::MODE_CHECK;
            5'h04: m = monitor_pkg::MODE_MEASURE;
            5'h08: m = monitor_pkg::MODE_SAMPLE;
            5'h10: m = monitor_pkg::MODE_PURGE;
            default: m = monitor_pkg::MODE_OFF;
        endcase
        return m;
    endfunction

    // step size for the threshold value
    function automatic logic [15:0] step_of(input logic [15:0] v);
        logic [15:0] s;
        s = monitor_pkg::STEP_HIGH;
        if (v < monitor_pkg::THR_LOW_EDGE)
            s = monitor_pkg::STEP_LOW;
        else if (v <= monitor_pkg::THR_MID_EDGE)
            s = monitor_pkg::STEP_MID;
        return s;
    endfunction

    monitor_pkg::mode_type mode;
    monitor_pkg::alarm_state_type alarm_q;
    monitor_pkg::screen_type screen_q;
    logic [31:0] ctrl_q;
    logic [15:0] alert_thr_q;
    logic [15:0] activity_q;
    logic [15:0] alarm_thr_q;
    logic [15:0] popup_val_q;
    logic [31:0] popup_cnt_q;
    logic popup_q;
    logic [31:0] relay_cnt_q;
    logic relay_test_q;
    logic [31:0] sec_cnt_q;
    logic [12:0] purge_left_q;
    logic [7:0] fail_q;
    logic alarm_hit;
    logic alert_hit;
    logic [15:0] step;
    logic [16:0] up_val;
    logic pump_on;
    logic charge_on;
    logic [7:0] aw_addr_q;
    logic aw_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held_q;
    logic wr_go;
    logic [31:0] rd_val;
    logic rd_hit;

    assign mode = decode_mode(selector_i);

    assign alarm_hit = (alarm_thr_q != 16'h0000) && (activity_q > alarm_thr_q);
    assign alert_hit = (alert_thr_q != 16'h0000) && (activity_q > alert_thr_q);

    // alarm latch: sounding, silenced, idle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            alarm_q <= monitor_pkg::ALM_IDLE;
        else
        begin
            unique case (alarm_q)
                monitor_pkg::ALM_IDLE:
                    if (alarm_hit || alert_hit)
                        alarm_q <= monitor_pkg::ALM_SOUNDING;
                monitor_pkg::ALM_SOUNDING:
                    if (ack_press_i && mode != monitor_pkg::MODE_CHECK)
                        alarm_q <= monitor_pkg::ALM_SILENCED;
                monitor_pkg::ALM_SILENCED:
                    if (alarm_hit || alert_hit)
                        alarm_q <= monitor_pkg::ALM_SILENCED;
                    else if (ack_press_i && mode != monitor_pkg::MODE_CHECK)
                        alarm_q <= monitor_pkg::ALM_IDLE;
            endcase
        end
    end

    // failure latch, set wins, cleared by press once the fault is gone
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            fail_q <= 8'h00;
        else if (mode == monitor_pkg::MODE_OFF)
            fail_q <= 8'h00;
        else if (ack_press_i)
            fail_q <= ~diag_ok_i;
        else
            fail_q <= fail_q | ~diag_ok_i;
    end

    // screen selection in check mode and pop-up takeover
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            screen_q <= monitor_pkg::SCR_CHECK1;
        else if (mode != monitor_pkg::MODE_CHECK)
            screen_q <= monitor_pkg::SCR_CHECK1;
        else if (ack_press_i && !popup_q)
            screen_q <= (screen_q == monitor_pkg::SCR_CHECK1) ? monitor_pkg::SCR_CHECK2
                                                                : monitor_pkg::SCR_CHECK1;
    end

    assign step = step_of(popup_val_q);
    assign up_val = {1'b0, popup_val_q} + {1'b0, step};

    // threshold adjust pop-up with quiet timer
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            popup_q <= 1'b0;
            popup_cnt_q <= 32'h0000_0000;
            popup_val_q <= monitor_pkg::ALARM_THR_RST;
            alarm_thr_q <= monitor_pkg::ALARM_THR_RST;
        end
        // adjustments outside check mode are ignored
        else if (mode != monitor_pkg::MODE_CHECK)
        begin
            popup_q <= 1'b0;
            popup_cnt_q <= 32'h0000_0000;
            popup_val_q <= alarm_thr_q;
        end
        // step opens pop-up and restarts timer
        else if (knob_step_i)
        begin
            popup_q <= 1'b1;
            popup_cnt_q <= 32'h0000_0000;
            if (knob_up_i)
                popup_val_q <= (up_val > {1'b0, monitor_pkg::THR_MAX}) ? monitor_pkg::THR_MAX : up_val[15:0];
            else if (popup_val_q > monitor_pkg::THR_LOW_EDGE)
                popup_val_q <= popup_val_q - step_of(popup_val_q - 16'h0001);
            else if (popup_val_q >= monitor_pkg::STEP_LOW)
                popup_val_q <= popup_val_q - monitor_pkg::STEP_LOW;
            else
                popup_val_q <= 16'h0000;
        end
        else if (popup_q)
        begin
            if (popup_cnt_q == POPUP_CYC - 1)
            begin
                popup_q <= 1'b0;
                alarm_thr_q <= popup_val_q;
            end
            else
                popup_cnt_q <= popup_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            relay_test_q <= 1'b1;
            relay_cnt_q <= 32'h0000_0000;
        end
        else if (relay_test_q)
        begin
            if (relay_cnt_q == RELAY_CYC - 1)
                relay_test_q <= 1'b0;
            relay_cnt_q <= relay_cnt_q + 32'h0000_0001;
        end
    end

    // purge countdown, reloads when purge not selected
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sec_cnt_q <= 32'h0000_0000;
            purge_left_q <= 13'(monitor_pkg::PURGE_S);
        end
        else if (mode != monitor_pkg::MODE_PURGE)
        begin
            sec_cnt_q <= 32'h0000_0000;
            purge_left_q <= 13'(monitor_pkg::PURGE_S);
        end
        else if (purge_left_q != 13'h0000)
        begin
            if (sec_cnt_q == SEC_CYC - 1)
            begin
                sec_cnt_q <= 32'h0000_0000;
                purge_left_q <= purge_left_q - 13'h0001;
            end
            else
                sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
        end
    end

    // pump per mode, purge stops at end of cycle
    assign pump_on = (mode == monitor_pkg::MODE_SAMPLE) ||
                     (mode == monitor_pkg::MODE_PURGE && purge_left_q != 13'h0000);
    assign charge_on = mains_i && (mode == monitor_pkg::MODE_SAMPLE || mode == monitor_pkg::MODE_MEASURE ||
                                   mode == monitor_pkg::MODE_PURGE);

    // registered actuator, display and sounder outputs
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            act_o <= '0;
            disp_o <= '0;
            sound_o <= '0;
        end
        else
        begin
            act_o.pump <= pump_on;
            act_o.heater <= pump_on && mode == monitor_pkg::MODE_PURGE && mains_i;
            // bias on test screen unless disabled
            act_o.bias <= screen_q == monitor_pkg::SCR_CHECK2 && !ctrl_q[monitor_pkg::CTRL_BIAS_DIS_BIT];
            act_o.charge <= charge_on;
            act_o.relay_pump <= pump_on || relay_test_q;
            act_o.relay_alarm <= alarm_q != monitor_pkg::ALM_IDLE || relay_test_q;
            disp_o.screen <= popup_q ? monitor_pkg::SCR_POPUP :
                             (mode == monitor_pkg::MODE_CHECK ? screen_q : monitor_pkg::SCR_RUN);
            disp_o.alarm_text <= alarm_q != monitor_pkg::ALM_IDLE;
            disp_o.alert_text <= alert_hit;
            disp_o.airflow_fail_text <= airflow_low_i && mode != monitor_pkg::MODE_OFF;
            disp_o.charge_icon <= charge_on;
            disp_o.diag_marks <= diag_ok_i;
            disp_o.fail_code <= fail_q;
            disp_o.popup_value <= popup_val_q;
            disp_o.purge_left <= purge_left_q;
            disp_o.show_concentration <= mode == monitor_pkg::MODE_SAMPLE || mode == monitor_pkg::MODE_MEASURE;
            sound_o.beep <= alarm_q == monitor_pkg::ALM_SOUNDING;
            sound_o.steady <= fail_q != 8'h00;
        end
    end

    // axi write: address and data caught in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= monitor_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q == monitor_pkg::CTRL_OFF || aw_addr_q == monitor_pkg::ALERT_THR_OFF ||
                                aw_addr_q == monitor_pkg::ACTIVITY_OFF) ? monitor_pkg::RESP_OKAY
                                                                        : monitor_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // software-written registers with byte strobes
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= monitor_pkg::CTRL_RST;
            alert_thr_q <= monitor_pkg::ALERT_THR_RST;
            activity_q <= 16'h0000;
        end
        else if (wr_go)
        begin
            for (int b = 0; b < 4; b++)
                if (w_strb_q[b] && aw_addr_q == monitor_pkg::CTRL_OFF)
                    ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
            for (int b = 0; b < 2; b++)
            begin
                if (w_strb_q[b] && aw_addr_q == monitor_pkg::ALERT_THR_OFF)
                    alert_thr_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
                if (w_strb_q[b] && aw_addr_q == monitor_pkg::ACTIVITY_OFF)
                    activity_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
            end
        end
    end

    // read decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr[7:0])
            monitor_pkg::CTRL_OFF: rd_val = ctrl_q;
            monitor_pkg::ALERT_THR_OFF: rd_val = {16'h0000, alert_thr_q};
            monitor_pkg::ACTIVITY_OFF: rd_val = {16'h0000, activity_q};
            monitor_pkg::DIAG_OFF: rd_val = {16'h0000, fail_q, diag_ok_i};
            monitor_pkg::STATUS_OFF: rd_val = {23'h000000, relay_test_q, popup_q, alarm_q, mode,
                                               disp_o.alert_text, disp_o.alarm_text};
            monitor_pkg::ALARM_THR_OFF: rd_val = {popup_val_q, alarm_thr_q};
            monitor_pkg::PURGE_LEFT_OFF: rd_val = {19'h00000, purge_left_q};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= monitor_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? monitor_pkg::RESP_OKAY : monitor_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // checks
    chk_off_no_charge: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mode == monitor_pkg::MODE_OFF |=> !act_o.charge) else $error("charging in off");
    chk_measure_pump_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mode == monitor_pkg::MODE_MEASURE |=> !act_o.pump) else $error("pump on in measure");
    chk_heater_mains: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        act_o.heater |-> $past(mains_i) && $past(mode) == monitor_pkg::MODE_PURGE) else $error("heater bad");
    chk_alarm_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_hit && alarm_q == monitor_pkg::ALM_IDLE |=> ##1 disp_o.alarm_text && sound_o.beep)
        else $error("alarm not latched");
    chk_silence_keeps: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_q == monitor_pkg::ALM_SOUNDING && ack_press_i && mode != monitor_pkg::MODE_CHECK
        |=> ##1 !sound_o.beep && disp_o.alarm_text) else $error("silence wrong");
    chk_clear_blocked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_q == monitor_pkg::ALM_SILENCED && alarm_hit |=> alarm_q != monitor_pkg::ALM_IDLE)
        else $error("cleared while high");
    chk_out_of_mode: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mode != monitor_pkg::MODE_CHECK |=> $stable(alarm_thr_q)) else $error("threshold changed");
    chk_thr_max: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        popup_val_q <= monitor_pkg::THR_MAX) else $error("threshold over max");
    chk_fail_steady: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        diag_ok_i != 8'hff && mode != monitor_pkg::MODE_OFF && !ack_press_i |=> ##1 sound_o.steady)
        else $error("failure not latched");
    chk_relay_test: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        relay_test_q |=> act_o.relay_pump && act_o.relay_alarm) else $error("relay test missing");
    cov_alarm_cycle: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_q == monitor_pkg::ALM_SILENCED ##1 alarm_q == monitor_pkg::ALM_IDLE);
    cov_popup_save: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) popup_q ##1 !popup_q);
    cov_purge_tick: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(purge_left_q[0]));

endmodule

// ===== pkg/monitor_pkg.sv
/*
 monitor_pkg: register map, field layout, reset values, timing constants and types
 for the monitor mode and alarm control block.
 assumes a 125 MHz system clock and 32-bit AXI4-Lite register access.
*/
package monitor_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 125000000;

    // timing constants in their own units
    localparam int unsigned POPUP_QUIET_S = 3;
    localparam int unsigned RELAY_TEST_S = 3;
    localparam int unsigned PURGE_S = 7200;
    localparam int unsigned POPUP_CYCLES = POPUP_QUIET_S * CLK_HZ;
    localparam int unsigned RELAY_CYCLES = RELAY_TEST_S * CLK_HZ;
    localparam int unsigned SEC_CYCLES = CLK_HZ;

    // threshold limits and steps
    localparam logic [15:0] THR_MAX = 16'h4e20;
    localparam logic [15:0] THR_LOW_EDGE = 16'h0064;
    localparam logic [15:0] THR_MID_EDGE = 16'h03e8;
    localparam logic [15:0] STEP_LOW = 16'h0005;
    localparam logic [15:0] STEP_MID = 16'h0032;
    localparam logic [15:0] STEP_HIGH = 16'h01f4;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] ALERT_THR_OFF = 8'h04;
    localparam logic [7:0] ACTIVITY_OFF = 8'h08;
    localparam logic [7:0] DIAG_OFF = 8'h0c;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    localparam logic [7:0] ALARM_THR_OFF = 8'h14;
    localparam logic [7:0] PURGE_LEFT_OFF = 8'h18;

    // control register fields
    localparam int CTRL_BIAS_DIS_BIT = 0;
    localparam int CTRL_SI_UNIT_BIT = 1;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] ALERT_THR_RST = 16'h0000;
    localparam logic [15:0] ALARM_THR_RST = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_CHECK,
        MODE_MEASURE,
        MODE_SAMPLE,
        MODE_PURGE
    } mode_type;

    typedef enum logic [1:0] {
        ALM_IDLE,
        ALM_SOUNDING,
        ALM_SILENCED
    } alarm_state_type;

    typedef enum logic [1:0] {
        SCR_CHECK1,
        SCR_CHECK2,
        SCR_RUN,
        SCR_POPUP
    } screen_type;

    // outputs toward the actuators and relays
    typedef struct packed {
        logic pump;
        logic heater;
        logic bias;
        logic charge;
        logic relay_pump;
        logic relay_alarm;
    } actuator_type;

    // display indications
    typedef struct packed {
        screen_type screen;
        logic alarm_text;
        logic alert_text;
        logic airflow_fail_text;
        logic charge_icon;
        logic [7:0] diag_marks;
        logic [7:0] fail_code;
        logic [15:0] popup_value;
        logic [12:0] purge_left;
        logic show_concentration;
    } display_type;

    // sounder drive
    typedef struct packed {
        logic beep;
        logic steady;
    } sounder_type;

endpackage

// ===== verif/monitor_mode_alarm_control_tb.sv
/*
 self-checking bench: relay test, modes, alarm, failure latch, threshold pop-up.
 assumes the block's short test counts 20, 10 and 4 cycles.
*/
`timescale 1ns/10ps
module monitor_mode_alarm_control_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [4:0] sel = 5'h00;
    logic pr = 1'h0;
    logic st = 1'h0;
    logic [7:0] dok = 8'hff;
    logic up = 1'h1, mn = 1'h1, air = 1'h0;
    logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, rd_d, r_d;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, press, step;
    logic [1:0] b_rsp, r_rsp;
    monitor_pkg::actuator_type act;
    monitor_pkg::display_type dsp;
    monitor_pkg::sounder_type snd;
    int bad_count = 0;
    int checks = 0;
    int i;
    operator_panel u_op (.clk_i(clk), .press_i(pr), .step_i(st), .press_o(press), .step_o(step));
    monitor_mode_alarm_control #(.POPUP_CYC(20), .RELAY_CYC(10), .SEC_CYC(4)) u_dut (
        .ref_clk_i(clk), .sys_rst_i(rst), .selector_i(sel), .ack_press_i(press), .knob_step_i(step),
        .knob_up_i(up), .mains_i(mn), .diag_ok_i(dok), .airflow_low_i(air),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .act_o(act), .disp_o(dsp), .sound_o(snd));
    // free-running 125 MHz clock
    initial
        forever #4 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ga, gw;
        pa = 1'h1;
        pw = 1'h1;
        aw_a <= {24'h0, a};
        w_d <= d;
        aw_v <= 1'h1;
        w_v <= 1'h1;
        b_r <= 1'h1;
        while (pa | pw)
        begin
            @(negedge clk);
            ga = aw_rdy & pa;
            gw = w_rdy & pw;
            @(posedge clk);
            if (ga) aw_v <= 1'h0;
            if (gw) w_v <= 1'h0;
            pa = pa & ~ga;
            pw = pw & ~gw;
        end
        do
        begin
            @(negedge clk);
            ga = b_v;
            @(posedge clk);
        end while (!ga);
        b_r <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic g;
        ar_a <= {24'h0, a};
        ar_v <= 1'h1;
        r_r <= 1'h1;
        do
        begin
            @(negedge clk);
            g = ar_rdy;
            @(posedge clk);
        end while (!g);
        ar_v <= 1'h0;
        do
        begin
            @(negedge clk);
            g = r_v;
            rd_d = r_d;
            @(posedge clk);
        end while (!g);
        r_r <= 1'h0;
        @(posedge clk);
    endtask
    task automatic push(input logic knob);
        if (knob) st <= 1'h1; else pr <= 1'h1;
        @(posedge clk);
        st <= 1'h0;
        pr <= 1'h0;
        cyc(4);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // relays forced on for the test span after reset
    task automatic t_relay();
        cyc(3);
        chk("relay_alarm", 16'h1, act.relay_alarm);
        chk("relay_pump", 16'h1, act.relay_pump);
        cyc(12);
        chk("relay_alarm", 16'h0, act.relay_alarm);
        $display("relay test done");
    endtask
    // each selector position except check, purge countdown, mains loss in purge
    task automatic t_modes();
        for (i = 0; i < 4; i++)
        begin
            sel <= 5'h01 << i + (i > 0);
            cyc(3);
            chk("pump", {15'h0, i > 1}, act.pump);
            chk("heater", {15'h0, i == 3}, act.heater);
            chk("charge", {15'h0, i > 0}, act.charge);
            chk("charge_icon", {15'h0, i > 0}, dsp.charge_icon);
            chk("concentration", {15'h0, i == 1 || i == 2}, dsp.show_concentration);
        end
        chk("purge_left", 16'h1c20, dsp.purge_left);
        cyc(4);
        chk("purge_left", 16'h1c1f, dsp.purge_left);
        mn <= 1'h0;
        cyc(3);
        chk("heater", 16'h0, act.heater);
        chk("relay_pump", 16'h1, act.relay_pump);
        mn <= 1'h1;
        $display("mode test done");
    endtask
    // alert level latches the alarm, a press silences it, a press while still high is ignored, a press after it falls clears it
    task automatic t_alarm();
        sel <= 5'h04;
        air <= 1'h1;
        wr(8'h04, 32'h32);
        wr(8'h08, 32'h64);
        cyc(4);
        chk("beep", 16'h1, snd.beep);
        chk("relay_alarm", 16'h1, act.relay_alarm);
        chk("airflow_fail", 16'h1, dsp.airflow_fail_text);
        air <= 1'h0;
        push(1'h0);
        chk("beep", 16'h0, snd.beep);
        push(1'h0);
        chk("alarm_text", 16'h1, dsp.alarm_text);
        wr(8'h08, 32'h0);
        cyc(4);
        chk("alert_text", 16'h0, dsp.alert_text);
        push(1'h0);
        chk("alarm_text", 16'h0, dsp.alarm_text);
        $display("alarm test done");
    endtask
    // short diagnostic fault stays latched
    task automatic t_fail();
        dok <= 8'hfe;
        cyc(4);
        chk("diag_marks", 16'hfe, dsp.diag_marks);
        dok <= 8'hff;
        cyc(4);
        chk("steady", 16'h1, snd.steady);
        chk("fail_code", 16'h1, dsp.fail_code);
        $display("failure test done");
    endtask
    // check screens, self-test bias and its disable
    task automatic t_check();
        sel <= 5'h02;
        cyc(4);
        push(1'h0);
        chk("bias", 16'h1, act.bias);
        wr(8'h00, 32'h1);
        cyc(2);
        chk("bias", 16'h0, act.bias);
        wr(8'h00, 32'h2);
        push(1'h0);
        chk("screen", 16'h0, dsp.screen);
        $display("check test done");
    endtask
    // knob steps, quiet-time save, restart, down step, out-of-mode steps
    task automatic t_adjust();
        push(1'h1);
        chk("screen", 16'h3, dsp.screen);
        chk("popup", 16'h5, dsp.popup_value);
        cyc(30);
        chk("screen", 16'h0, dsp.screen);
        rd(8'h14);
        chk("alarm_thr", 16'h5, rd_d[15:0]);
        push(1'h1);
        cyc(8);
        push(1'h1);
        cyc(10);
        rd(8'h14);
        chk("alarm_thr", 16'h5, rd_d[15:0]);
        chk("popup", 16'hf, rd_d[31:16]);
        cyc(30);
        up <= 1'h0;
        push(1'h1);
        chk("popup", 16'ha, dsp.popup_value);
        sel <= 5'h04;
        up <= 1'h1;
        push(1'h1);
        cyc(30);
        rd(8'h14);
        chk("alarm_thr", 16'hf, rd_d[15:0]);
        rd(8'h1c);
        chk("rresp", 16'h2, r_rsp);
        wr(8'h08, 32'h14);
        cyc(4);
        chk("beep", 16'h1, snd.beep);
        $display("adjust test done");
    endtask
    // main sequence of scenarios
    initial
    begin
        cyc(20);
        rst <= 1'h0;
        t_relay();
        t_modes();
        t_alarm();
        t_fail();
        t_check();
        t_adjust();
        conclude();
    end
    // watchdog against a hung handshake
    initial
    begin
        #400000;
        bad_count++;
        conclude();
    end
endmodule

// ===== verif/operator_panel.sv
/*
 operator panel model: debounced push button and knob steps as one-cycle pulses.
 assumes requests come from the bench right after a rising edge.
*/
`timescale 1ns/10ps
module operator_panel (
    input wire logic clk_i,
    input wire logic press_i,
    input wire logic step_i,
    output logic press_o,
    output logic step_o
);
    // pulses leave one edge after the request, as a debouncer would
    always_ff @(posedge clk_i)
    begin
        press_o <= press_i;
        step_o <= step_i;
    end
endmodule
